// file: hw/fast_output_mode_pwm.v
// Two-channel fast output block: direct, pulse-width, compare and stepper
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`include "fast_output_defines.vh"
`default_nettype none
module fast_output_mode_pwm #(
   parameter CLK_HZ = 40000000 // System clock rate in hertz
) (
   input wire clk, // System clock
   input wire resetn, // Asynchronous reset, active low
   input wire [7:0] address, // Avalon byte address
   input wire read, // Avalon read strobe
   input wire write, // Avalon write strobe
   input wire [31:0] writedata, // Avalon write data
   input wire [3:0] byteenable, // Avalon byte lanes
   output reg [31:0] readdata, // Avalon read data
   output wire waitrequest, // Avalon stall
   input wire [1:0] compare_level, // Compare result from counters
   output reg fast_output_one, // Fast output pin 1
   output reg fast_output_two // Fast output pin 2
);

   // One wait cycle per access: answer registered on the first edge that sees the request
   reg ack;
   assign waitrequest = (read | write) & ~ack;
   wire take = (read | write) & ack;

   reg [31:0] glb;
   reg [31:0] ctrl [0:1];
   reg [31:0] duty [0:1];
   reg [31:0] rate [0:1];
   reg [31:0] sduty [0:1];
   reg [31:0] srate [0:1];
   reg [31:0] spar [0:9];
   wire [3:0] st [0:1];
   wire [1:0] lvl;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] be;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b])
               merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // True for the five stepper parameter words of a channel
   function is_step;
      input [7:0] o;
      begin
         is_step = (o >= `REG_STEP_START_HZ) && (o <= `REG_STEP_DECEL);
      end
   endfunction

   // Flat slot of a stepper word: five words per channel
   function [3:0] step_slot;
      input s;
      input [7:0] o;
      begin
         step_slot = (s ? 4'd5 : 4'd0) + (o[5:2] - 4'd5);
      end
   endfunction

   wire stop = glb[`GLB_STOP_BIT];
   wire hold_zero = glb[`GLB_DOWNLOAD_BIT];
   wire ch_sel = address[6];
   wire [7:0] off = {2'b00, address[5:0]};
   wire in_ch = ~address[7];

   integer i;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack <= 1'b0;
         readdata <= 32'h0000_0000;
         glb <= 32'h0000_0000;
         for (i = 0; i < 2; i = i + 1) begin
            ctrl[i] <= 32'h0000_0000;
            duty[i] <= 32'h0000_0000;
            rate[i] <= 32'h0000_0000;
            sduty[i] <= 32'h0000_0000;
            srate[i] <= 32'h0000_0000;
         end
         for (i = 0; i < 10; i = i + 1)
            spar[i] <= 32'h0000_0000;
      end else begin
         ack <= (read | write) & ~ack;
         if (take & write) begin
            if (in_ch) begin
               case (off)
                  `REG_CTRL: ctrl[ch_sel] <= merge(ctrl[ch_sel],
                     writedata, byteenable);
                  `REG_DUTY: duty[ch_sel] <= merge(duty[ch_sel],
                     writedata, byteenable);
                  `REG_RATE: rate[ch_sel] <= merge(rate[ch_sel],
                     writedata, byteenable);
                  `REG_STOP_DUTY: sduty[ch_sel] <= merge(sduty[ch_sel],
                     writedata, byteenable);
                  `REG_STOP_RATE: srate[ch_sel] <= merge(srate[ch_sel],
                     writedata, byteenable);
                  default: begin
                     if (is_step(off))
                        spar[step_slot(ch_sel, off)] <=
                           merge(spar[step_slot(ch_sel, off)],
                              writedata, byteenable);
                  end
               endcase
            end else if (address == `REG_GLOBAL) begin
               glb <= merge(glb, writedata, byteenable);
            end
         end
         // Load read data in the wait cycle so it stands as the stall drops
         if (read & ~ack) begin
            readdata <= 32'h0000_0000;
            if (in_ch) begin
               case (off)
                  `REG_CTRL: readdata <= ctrl[ch_sel];
                  `REG_DUTY: readdata <= duty[ch_sel];
                  `REG_RATE: readdata <= rate[ch_sel];
                  `REG_STOP_DUTY: readdata <= sduty[ch_sel];
                  `REG_STOP_RATE: readdata <= srate[ch_sel];
                  `REG_STATUS: readdata <= {28'h0, st[ch_sel]};
                  default: begin
                     if (is_step(off))
                        readdata <= spar[step_slot(ch_sel, off)];
                  end
               endcase
            end else if (address == `REG_GLOBAL) begin
               readdata <= glb;
            end
         end
      end
   end

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : chan
         wire [1:0] mode = ctrl[c][`CTRL_MODE_LSB +: 2];
         // Period and high time in clocks, latched at period end
         reg [31:0] per_q;
         reg [31:0] hi_q;
         reg [31:0] cnt;
         reg pwm_out;
         reg armed;
         wire [31:0] f_sel = stop ? srate[c] : rate[c];
         wire [31:0] d_sel = stop ? sduty[c] : duty[c];
         wire [31:0] d_clip = (d_sel > `DUTY_FULL) ? `DUTY_FULL : d_sel;
         wire [31:0] per_n = (f_sel == 32'h0) ? 32'h1 :
            CLK_HZ / f_sel;
         wire [63:0] hi_w = per_n * d_clip / `DUTY_FULL;
         wire cfg_ok = (f_sel != 32'h0) && (d_sel != 32'h0);
         // Download outranks hold, so a load can never leave the PWM output high
         wire hold = stop & ctrl[c][`CTRL_STOP_HOLD_BIT] & ~hold_zero;
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               per_q <= 32'h0;
               hi_q <= 32'h0;
               cnt <= 32'h0;
               pwm_out <= 1'b0;
               armed <= 1'b0;
            end else if (hold) begin
               pwm_out <= pwm_out;
            end else if (hold_zero | ~ctrl[c][`CTRL_EN_BIT] | ~cfg_ok) begin
               // Low until both values non-zero
               pwm_out <= 1'b0;
               armed <= 1'b0;
               cnt <= 32'h0;
            end else begin
               if (!armed || cnt + 32'h1 >= per_q) begin
                  armed <= 1'b1;
                  cnt <= 32'h0;
                  per_q <= per_n;
                  hi_q <= hi_w[31:0];
                  pwm_out <= (hi_w[31:0] != 32'h0);
               end else begin
                  cnt <= cnt + 32'h1;
                  pwm_out <= (cnt + 32'h1 < hi_q);
               end
            end
         end

         // Stepper
         reg [31:0] p_start;
         reg [31:0] p_run;
         reg [31:0] p_acc;
         reg [31:0] p_rc;
         reg [31:0] p_dec;
         reg [31:0] scnt;
         reg [31:0] steps;
         reg [31:0] per_s;
         reg [1:0] phase;
         reg busy;
         reg err;
         reg step_out;
         wire go = ctrl[c][`CTRL_START_BIT] & (mode == `MODE_STEPPER);
         wire [31:0] a0 = spar[c*5];
         wire [31:0] a1 = spar[c*5 + 1];
         wire [31:0] a2 = spar[c*5 + 2];
         wire [31:0] a4 = spar[c*5 + 4];
         wire bad = (a1 == 32'h0) || (a2 == 32'h1) || (a4 == 32'h1) ||
            (((a2 != 32'h0) || (a4 != 32'h0)) &&
             ((a0 == 32'h0) || (a0 > a1)));
         // Linear ramp between start and run rate by step index
         wire [31:0] span = p_run - p_start;
         wire [31:0] n_den = (phase == 2'd0) ? p_acc : p_dec;
         wire [63:0] ramp = span * steps / ((n_den > 32'h1) ?
            (n_den - 32'h1) : 32'h1);
         wire [31:0] f_acc = p_start + ramp[31:0];
         wire [31:0] f_dec = p_run - ramp[31:0];
         wire [31:0] f_now = (phase == 2'd0) ? f_acc :
            (phase == 2'd1) ? p_run : f_dec;
         wire [31:0] per_f = CLK_HZ / ((f_now == 32'h0) ? 32'h1 : f_now);
         wire [31:0] ph_len = (phase == 2'd0) ? p_acc :
            (phase == 2'd1) ? p_rc : p_dec;
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               p_start <= 32'h0;
               p_run <= 32'h0;
               p_acc <= 32'h0;
               p_rc <= 32'h0;
               p_dec <= 32'h0;
               scnt <= 32'h0;
               steps <= 32'h0;
               per_s <= 32'h0;
               phase <= 2'd0;
               busy <= 1'b0;
               err <= 1'b0;
               step_out <= 1'b0;
            end else if (stop) begin
               busy <= 1'b0;
               step_out <= 1'b0;
               steps <= 32'h0;
               scnt <= 32'h0;
            end else if (!busy) begin
               step_out <= 1'b0;
               if (go & ~err | go & ~bad & (steps == 32'h0)) begin
                  err <= bad;
                  if (!bad) begin
                     // Captured once; later writes wait for the next start
                     p_start <= a0;
                     p_run <= a1;
                     p_acc <= a2;
                     p_rc <= spar[c*5 + 3];
                     p_dec <= a4;
                     busy <= 1'b1;
                     phase <= 2'd0;
                     steps <= 32'h0;
                     scnt <= 32'h0;
                     per_s <= 32'h0;
                  end
               end
               if (!go)
                  steps <= 32'h0;
            end else if (!go) begin
               busy <= 1'b0;
               err <= 1'b1;
               step_out <= 1'b0;
            end else if (steps >= ph_len) begin
               steps <= 32'h0;
               if (phase == 2'd2) begin
                  busy <= 1'b0;
                  steps <= 32'h1;
               end else
                  phase <= phase + 2'd1;
            end else if (scnt == 32'h0) begin
               per_s <= per_f;
               scnt <= 32'h1;
               step_out <= 1'b1;
            end else if (scnt + 32'h1 >= per_s) begin
               scnt <= 32'h0;
               steps <= steps + 32'h1;
               step_out <= 1'b0;
            end else begin
               scnt <= scnt + 32'h1;
               step_out <= (scnt + 32'h1) < {1'b0, per_s[31:1]};
            end
         end

         reg lv;
         always @* begin
            case (mode)
               `MODE_DIRECT:
                  lv = ctrl[c][`CTRL_DIRECT_BIT] & ~hold_zero;
               `MODE_PWM: lv = pwm_out;
               `MODE_COMPARE: lv = compare_level[c];
               `MODE_STEPPER: lv = step_out;
               default: lv = 1'b0;
            endcase
         end
         assign lvl[c] = lv;
         assign st[c] = {busy, err, ~busy, lv};
      end
   endgenerate

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fast_output_one <= 1'b0;
         fast_output_two <= 1'b0;
      end else begin
         fast_output_one <= lvl[0];
         fast_output_two <= lvl[1];
      end
   end
endmodule // fast_output_mode_pwm
`default_nettype wire

// file: pkg/fast_output_defines.vh
// Register map, field layout and timing constants for the fast output block
`ifndef FAST_OUTPUT_DEFINES_VH
`define FAST_OUTPUT_DEFINES_VH

`define CLK_HZ 32'd40000000
`define DUTY_FULL 32'd32000

// Word offsets (byte address), per channel block of 0x40
`define CH_STRIDE 8'h40
`define REG_CTRL 8'h00
`define REG_DUTY 8'h04
`define REG_RATE 8'h08
`define REG_STOP_DUTY 8'h0c
`define REG_STOP_RATE 8'h10
`define REG_STEP_START_HZ 8'h14
`define REG_STEP_RUN_HZ 8'h18
`define REG_STEP_ACCEL 8'h1c
`define REG_STEP_RUN_CNT 8'h20
`define REG_STEP_DECEL 8'h24
`define REG_STATUS 8'h28
`define REG_GLOBAL 8'h80

// Channel control fields
`define CTRL_MODE_LSB 0
`define CTRL_EN_BIT 2
`define CTRL_STOP_HOLD_BIT 3
`define CTRL_DIRECT_BIT 4
`define CTRL_START_BIT 5
// Global fields
`define GLB_STOP_BIT 0
`define GLB_DOWNLOAD_BIT 1
// Status fields
`define ST_LEVEL_BIT 0
`define ST_READY_BIT 1
`define ST_ERROR_BIT 2
`define ST_ACTIVE_BIT 3

`define MODE_DIRECT 2'd0
`define MODE_PWM 2'd1
`define MODE_COMPARE 2'd2
`define MODE_STEPPER 2'd3

`endif

// file: test/fast_output_assertions.sv
// Port-level checker for the fast output block
`default_nettype none
module fast_output_checks (
   input wire logic clk, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic [7:0] address, // Bus address
   input wire logic read, // Bus read
   input wire logic write, // Bus write
   input wire logic [31:0] writedata, // Bus write data
   input wire logic waitrequest, // Bus stall
   input wire logic [1:0] compare_level, // Compare inputs
   input wire logic fast_output_one, // Pin 1
   input wire logic fast_output_two // Pin 2
);
   logic [5:0] c0, c1;
   logic [1:0] glb;
   logic wrote;
   // Shadow of the control bytes, taken only at accepted writes
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         c0 <= 6'h00;
         c1 <= 6'h00;
         glb <= 2'h0;
         wrote <= 1'b0;
      end else if (write && !waitrequest) begin
         wrote <= 1'b1;
         if (address == 8'h00) c0 <= writedata[5:0];
         if (address == 8'h40) c1 <= writedata[5:0];
         if (address == 8'h80) glb <= writedata[1:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_wait; $rose(read || write) |-> waitrequest ##1 !waitrequest;
   endproperty
   a_wait: assert property (p_wait)
      else $error("Wait cycle count wrong");
   property p_idle; !read && !write |-> !waitrequest;
   endproperty
   a_idle: assert property (p_idle)
      else $error("Stall while idle");
   property p_boot; !wrote |-> !fast_output_one && !fast_output_two;
   endproperty
   a_boot: assert property (p_boot)
      else $error("Pin high before setup");
   property p_direct; (c0[1:0] == 2'd0 && glb == 2'd0 && $stable(c0))[*4]
      |-> fast_output_one == c0[4]; endproperty
   a_direct: assert property (p_direct)
      else $error("Pin 1 not direct");
   property p_direct_two; (c1[1:0] == 2'd0 && glb == 2'd0 && $stable(c1))[*4]
      |-> fast_output_two == c1[4]; endproperty
   a_direct_two: assert property (p_direct_two)
      else $error("Pin 2 wrong");
   property p_compare; (c0[1:0] == 2'd2 && glb == 2'd0 && $stable(c0)
      && $stable(compare_level))[*4] |-> fast_output_one == compare_level[0];
   endproperty
   a_compare: assert property (p_compare)
      else $error("Compare wrong");
   property p_download; (glb[1] && !c0[1])[*4] |-> !fast_output_one;
   endproperty
   a_download: assert property (p_download)
      else $error("Pin in load");
   property p_step_stop; (c0[1:0] == 2'd3 && glb[0])[*3] |-> !fast_output_one;
   endproperty
   a_step_stop: assert property (p_step_stop)
      else $error("Step in stop");
endmodule // fast_output_checks
bind fast_output_mode_pwm fast_output_checks u_chk (.clk(clk),
   .resetn(resetn), .address(address), .read(read), .write(write),
   .writedata(writedata), .waitrequest(waitrequest),
   .compare_level(compare_level),
   .fast_output_one(fast_output_one), .fast_output_two(fast_output_two));
`default_nettype wire

// file: test/pulse_load.sv
// Load model on a fast output pin: measures high time and period
`default_nettype none
module pulse_load (
   input wire logic clk, // System clock
   input wire logic pin, // Fast output pin
   output logic [15:0] high_len, // Last high time in cycles
   output logic [15:0] period_len // Last period in cycles
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last = 1'b0;
   logic [15:0] run = 16'h0;
   logic [15:0] hi = 16'h0;
   initial high_len = 16'h0;
   initial period_len = 16'h0;
   // Figures only move at a rise, so a pin stuck at one level keeps them
   always @(posedge clk) begin
      last <= pin;
      if (pin && !last) begin
         period_len <= run;
         high_len <= hi;
         run <= 16'h1;
         hi <= 16'h1;
      end else begin
         run <= run + 16'h1;
         hi <= hi + {15'h0, pin};
      end
   end
endmodule // pulse_load
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the fast output block
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
   err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
   end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic [1:0] compare_level = 2'h0;
   logic [31:0] readdata, rd;
   logic waitrequest, pin_one, pin_two, any1, any2, all1;
   logic [15:0] hi1, per1, hi2, per2;
   int err_count = 0;
   int checks_done = 0;
   always #12.5 clk = ~clk;
   fast_output_mode_pwm #(.CLK_HZ(40000000)) dut (.clk(clk), .resetn(resetn),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .compare_level(compare_level), .fast_output_one(pin_one),
      .fast_output_two(pin_two));
   pulse_load load_one (.clk(clk), .pin(pin_one), .high_len(hi1),
      .period_len(per1));
   pulse_load load_two (.clk(clk), .pin(pin_two), .high_len(hi2),
      .period_len(per2));
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Request starts on an edge and is held until the stall drops
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (waitrequest !== 1'b0) begin
         err_count++;
         tally_and_finish;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdck(input logic [7:0] a, input logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      `CHK("readback", e, rd & m)
   endtask
   // Settle for n cycles, then record what both pins did over n more
   task automatic watch(input int n);
      cycles(n);
      any1 = 1'b0;
      any2 = 1'b0;
      all1 = 1'b1;
      repeat (n) begin
         @(posedge clk);
         any1 |= pin_one;
         any2 |= pin_two;
         all1 &= pin_one;
      end
   endtask
   task automatic t_reset;
      `CHK("pins at reset", 2'b00, {pin_two, pin_one})
      rdck(8'h00, 32'hffffffff, 32'h0);
      rdck(8'hfc, 32'hffffffff, 32'h0);
   endtask
   task automatic t_direct;
      wr(8'h00, 32'h10);
      cycles(4);
      `CHK("direct pins", 2'b01, {pin_two, pin_one})
      rdck(8'h28, 32'h1, 32'h1);
      wr(8'h80, 32'h2);
      cycles(5);
      `CHK("download", 1'b0, pin_one)
      wr(8'h80, 32'h0);
      wr(8'h40, 32'h10);
      wr(8'h00, 32'h0);
      cycles(4);
      `CHK("direct two", 2'b10, {pin_two, pin_one})
      wr(8'h40, 32'h0);
   endtask
   task automatic t_compare;
      wr(8'h00, 32'h2);
      compare_level <= 2'b01;
      cycles(4);
      `CHK("compare high", 1'b1, pin_one)
      compare_level <= 2'b10;
      cycles(4);
      `CHK("compare low", 1'b0, pin_one)
   endtask
   task automatic t_pwm;
      wr(8'h00, 32'h5);
      wr(8'h08, 32'd400000);
      watch(150);
      `CHK("rate only", 1'b0, any1)
      wr(8'h04, 32'd8000);
      cycles(400);
      `CHK("period", 16'd100, per1)
      `CHK("quarter", 16'd25, hi1)
      wr(8'h04, 32'd16000);
      cycles(300);
      `CHK("half", 16'd50, hi1)
      wr(8'h04, 32'd0);
      watch(300);
      `CHK("duty zero", 1'b0, any1)
      wr(8'h04, 32'd32000);
      watch(300);
      `CHK("duty full", 1'b1, all1)
      wr(8'h40, 32'h5);
      wr(8'h44, 32'd4000);
      wr(8'h48, 32'd200000);
      cycles(700);
      `CHK("ch2 period", 16'd200, per2)
      `CHK("ch2 high", 16'd25, hi2)
   endtask
   task automatic t_stop;
      wr(8'h0c, 32'd16000);
      wr(8'h10, 32'd200000);
      wr(8'h80, 32'h1);
      cycles(700);
      `CHK("stop period", 16'd200, per1)
      `CHK("stop high", 16'd100, hi1)
      watch(300);
      `CHK("stop zero", 1'b0, any2)
      wr(8'h80, 32'h0);
      wr(8'h00, 32'hd);
      wr(8'h80, 32'h1);
      watch(300);
      `CHK("stop hold", 1'b1, all1)
      wr(8'h80, 32'h0);
   endtask
   task automatic t_step;
      wr(8'h14, 32'd100000);
      wr(8'h18, 32'd100000);
      wr(8'h20, 32'd1000);
      wr(8'h00, 32'h23);
      cycles(1200);
      wr(8'h18, 32'd50000);
      cycles(1200);
      `CHK("step period", 16'd400, per1)
      wr(8'h00, 32'h03);
      cycles(4);
      rdck(8'h28, 32'h4, 32'h4);
      wr(8'h18, 32'd100000);
      wr(8'h00, 32'h23);
      cycles(1000);
      rdck(8'h28, 32'h4, 32'h0);
      wr(8'h80, 32'h1);
      watch(4);
      `CHK("step stop", 1'b0, any1)
      rdck(8'h28, 32'ha, 32'h2);
      wr(8'h00, 32'h0);
      wr(8'h80, 32'h0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_direct;
      t_compare;
      t_pwm;
      t_stop;
      t_step;
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire
